// file: shared/sns_pkg.sv
/*
 * constants, opcode fields and types of the subtract / nibble swap datapath.
 * assumes a 14-bit instruction word and a 128-entry file of 8-bit registers.
 */
package sns_pkg;

   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned ADDR_W  = 7;
   localparam int unsigned INSN_W  = 14;
   localparam int unsigned NIB_W   = 4;
   localparam int unsigned FILE_DEPTH = 128;

   // ----------------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------------
   localparam int unsigned DEST_BIT      = 7;
   localparam int unsigned LSUB_OPC_LSB  = 9;
   localparam int unsigned FILE_OPC_LSB  = 8;
   localparam logic [4:0]  LSUB_OPC      = 5'h1E;   // 11 110x
   localparam logic [5:0]  FSUB_OPC      = 6'h02;   // 00 0010
   localparam logic [5:0]  SWAP_OPC      = 6'h0E;   // 00 1110

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  WORK_RST      = 8'h00;
   localparam logic        FLAG_RST      = 1'b0;

   // ----------------------------------------------------------------------
   // timing: cycles from instruction taken to done pulse
   // ----------------------------------------------------------------------
   localparam int unsigned DONE_LATENCY  = 2;

   typedef enum logic [3:0] {
      OP_NONE = 4'h1,
      OP_LSUB = 4'h2,
      OP_FSUB = 4'h4,
      OP_SWAP = 4'h8
   } sns_op_e;

endpackage

// file: design/sns_file_mem.sv
/*
 * file register memory: one write port, one read port, registered read data.
 * assumes a single clock; contents are not reset.
 */
`timescale 1ns/10ps
module sns_file_mem #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 128,
   parameter int unsigned AW    = 7
) (
   // clock
   input  wire logic             sys_clk_i,
   // write port
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // read port
   input  wire logic [AW-1:0]    rd_addr_i,
   output logic      [WIDTH-1:0] rd_data_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule

// file: design/sns_alu.sv
/*
 * subtract and nibble swap datapath slice of an 8-bit core: working register,
 * status flags, file register memory and a two-stage issue/execute pipe.
 * assumes instruction and load ports come from logic on sys_clk_i.
 */
`timescale 1ns/10ps
// Operation
// - literal-subtract writes literal minus working register to it; flags updated.
// - file-subtract computes file register minus working register in two cycles.
// - destination bit 0 writes working register, 1 writes back the file register.
// - carry after subtraction is inverted borrow: 1 when result is zero or positive.
module sns_alu
   import sns_pkg::*;
(
   // clock and reset
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   // instruction issue
   input  wire logic                        insn_valid_i,
   input  wire logic [sns_pkg::INSN_W-1:0]  insn_i,
   // working register load
   input  wire logic                        work_load_i,
   input  wire logic [sns_pkg::DATA_W-1:0]  work_data_i,
   // file register load
   input  wire logic                        file_load_i,
   input  wire logic [sns_pkg::ADDR_W-1:0]  file_addr_i,
   input  wire logic [sns_pkg::DATA_W-1:0]  file_data_i,
   // results and status
   output logic      [sns_pkg::DATA_W-1:0]  work_o,
   output logic                             carry_o,
   output logic                             digit_carry_flag_o,
   output logic                             zero_flag_o,
   output logic      [sns_pkg::DATA_W-1:0]  result_o,
   output logic                             done_o,
   output logic                             unsupported_o
);
   import sns_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] w;
      logic              c;
      logic              dig_c;
      logic              z;
      logic              ex_valid;
      sns_op_e           ex_op;
      logic              ex_dest;
      logic [ADDR_W-1:0] ex_addr;
      logic [DATA_W-1:0] ex_lit;
      logic              fwd_hit;
      logic [DATA_W-1:0] fwd_data;
      logic [DATA_W-1:0] result;
      logic              done;
      logic              unsupported;
   } sns_state_s;

   sns_state_s st;
   sns_state_s next_st;

   logic [DATA_W-1:0] mem_rdata;
   logic [DATA_W-1:0] opnd;
   logic [DATA_W-1:0] minuend;
   logic              mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W+1:0] sub_out;
   sns_op_e           dec_op;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // returns {carry, digit carry, difference}; carries are inverted borrows
   function automatic logic [DATA_W+1:0] sub8(input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
      logic [DATA_W-1:0] diff;
      diff = a - b;
      return {(a >= b), (a[NIB_W-1:0] >= b[NIB_W-1:0]), diff};
   endfunction

   // exchanges the two nibbles of a byte
   function automatic logic [DATA_W-1:0] swap_nib(input logic [DATA_W-1:0] v);
      return {v[NIB_W-1:0], v[DATA_W-1:NIB_W]};
   endfunction

   function automatic sns_op_e decode(input logic [INSN_W-1:0] i);
      sns_op_e op;
      op = OP_NONE;
      if (i[INSN_W-1:LSUB_OPC_LSB] == LSUB_OPC) begin
         op = OP_LSUB;
      end else if (i[INSN_W-1:FILE_OPC_LSB] == FSUB_OPC) begin
         op = OP_FSUB;
      end else if (i[INSN_W-1:FILE_OPC_LSB] == SWAP_OPC) begin
         op = OP_SWAP;
      end
      return op;
   endfunction

   // ----------------------------------------------------------------------
   // file register memory
   // ----------------------------------------------------------------------
   sns_file_mem #(
      .WIDTH (DATA_W),
      .DEPTH (FILE_DEPTH),
      .AW    (ADDR_W)
   ) u_file (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (mem_we),
      .wr_addr_i (mem_waddr),
      .wr_data_i (mem_wdata),
      .rd_addr_i (insn_i[ADDR_W-1:0]),
      .rd_data_o (mem_rdata)
   );

   // ----------------------------------------------------------------------
   // execute datapath
   // ----------------------------------------------------------------------
   // a write in the issue cycle misses the registered read, so forward it
   assign opnd    = st.fwd_hit ? st.fwd_data : mem_rdata;
   assign minuend = (st.ex_op == OP_LSUB) ? st.ex_lit : opnd;
   assign sub_out = sub8(minuend, st.w);
   assign dec_op  = decode(insn_i);

   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = file_addr_i;
      mem_wdata = file_data_i;
      if (st.ex_valid && st.ex_dest &&
          (st.ex_op == OP_FSUB || st.ex_op == OP_SWAP)) begin
         mem_we    = 1'b1;
         mem_waddr = st.ex_addr;
         mem_wdata = (st.ex_op == OP_FSUB) ? sub_out[DATA_W-1:0] : swap_nib(opnd);
      end else if (file_load_i) begin
         mem_we    = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_st             = st;
      next_st.done        = 1'b0;
      next_st.unsupported = 1'b0;
      if (work_load_i) begin
         next_st.w = work_data_i;
      end
      if (st.ex_valid) begin
         next_st.done = 1'b1;
         case (st.ex_op)
            OP_LSUB: begin
               next_st.result = sub_out[DATA_W-1:0];
               next_st.w      = sub_out[DATA_W-1:0];
               next_st.c      = sub_out[DATA_W+1];
               next_st.dig_c  = sub_out[DATA_W];
               next_st.z      = (sub_out[DATA_W-1:0] == '0);
            end
            OP_FSUB: begin
               next_st.result = sub_out[DATA_W-1:0];
               if (!st.ex_dest) begin
                  next_st.w = sub_out[DATA_W-1:0];
               end
               next_st.c      = sub_out[DATA_W+1];
               next_st.dig_c  = sub_out[DATA_W];
               next_st.z      = (sub_out[DATA_W-1:0] == '0);
            end
            OP_SWAP: begin
               next_st.result = swap_nib(opnd);
               if (!st.ex_dest) begin
                  next_st.w = swap_nib(opnd);
               end
            end
            default: begin
               next_st.unsupported = 1'b1;
            end
         endcase
      end
      next_st.ex_valid = insn_valid_i;
      next_st.ex_op    = dec_op;
      next_st.ex_dest  = insn_i[DEST_BIT];
      next_st.ex_addr  = insn_i[ADDR_W-1:0];
      next_st.ex_lit   = insn_i[DATA_W-1:0];
      next_st.fwd_hit  = mem_we && (mem_waddr == insn_i[ADDR_W-1:0]);
      next_st.fwd_data = mem_wdata;
      if (rst_i) begin
         next_st             = '0;
         next_st.w           = WORK_RST;
         next_st.c           = FLAG_RST;
         next_st.dig_c       = FLAG_RST;
         next_st.z           = FLAG_RST;
         next_st.ex_op       = OP_NONE;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      st <= next_st;
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign work_o             = st.w;
   assign carry_o            = st.c;
   assign digit_carry_flag_o = st.dig_c;
   assign zero_flag_o        = st.z;
   assign result_o           = st.result;
   assign done_o             = st.done;
   assign unsupported_o      = st.unsupported;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_LSUB_TO_WORK: assert property (
      st.ex_valid && st.ex_op == OP_LSUB && !work_load_i |=>
         work_o == $past(st.ex_lit - st.w) && done_o)
      else $error("literal subtract result wrong");

   AST_FSUB_RESULT: assert property (
      insn_valid_i && dec_op == OP_FSUB ##1 st.ex_valid |=>
         result_o == $past(opnd - st.w) && done_o)
      else $error("file subtract result wrong");

   AST_DEST_FILE: assert property (
      st.ex_valid && st.ex_op == OP_FSUB && st.ex_dest && !work_load_i |->
         mem_we && mem_waddr == st.ex_addr ##1 work_o == $past(work_o))
      else $error("file destination not honoured");

   AST_CARRY_BORROW: assert property (
      st.ex_valid && (st.ex_op == OP_LSUB || st.ex_op == OP_FSUB) |=>
         carry_o == ($past(minuend) >= $past(st.w)))
      else $error("carry is not inverted borrow");

   AST_SWAP_FLAGS: assert property (
      st.ex_valid && st.ex_op == OP_SWAP |=>
         result_o == {$past(opnd[3:0]), $past(opnd[7:4])} && $stable(carry_o) &&
         $stable(zero_flag_o) && $stable(digit_carry_flag_o))
      else $error("nibble swap wrong or flags changed");

   COV_NEG_RESULT: cover property (st.ex_valid && st.ex_op == OP_LSUB && !sub_out[DATA_W+1]);
   COV_FSUB_FWD:   cover property (st.ex_valid && st.ex_op == OP_FSUB && st.fwd_hit);
   COV_SWAP_FILE:  cover property (st.ex_valid && st.ex_op == OP_SWAP && st.ex_dest);

endmodule

// file: testbench/sns_alu_tb_top.sv
/*
 * self-checking bench for the subtract / nibble swap datapath slice.
 * assumes sns_pkg and design/sns_alu.sv are compiled first.
 */
`timescale 1ns/10ps
module sns_alu_tb_top;
   import sns_pkg::*;

   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic              sys_clk_i = 1'b0;
   logic              rst_i;
   logic              insn_valid_i;
   logic [INSN_W-1:0] insn_i;
   logic              work_load_i;
   logic [DATA_W-1:0] work_data_i;
   logic              file_load_i;
   logic [ADDR_W-1:0] file_addr_i;
   logic [DATA_W-1:0] file_data_i;
   logic [DATA_W-1:0] work_o;
   logic              carry_o;
   logic              digit_carry_flag_o;
   logic              zero_flag_o;
   logic [DATA_W-1:0] result_o;
   logic              done_o;
   logic              unsupported_o;
   int                err_total = 0;
   int                checks    = 0;
   logic              exp_c;
   logic              exp_z;

   always #5 sys_clk_i = ~sys_clk_i;

   sns_alu i_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
      .work_load_i(work_load_i), .work_data_i(work_data_i), .file_load_i(file_load_i),
      .file_addr_i(file_addr_i), .file_data_i(file_data_i), .work_o(work_o),
      .carry_o(carry_o), .digit_carry_flag_o(digit_carry_flag_o),
      .zero_flag_o(zero_flag_o), .result_o(result_o), .done_o(done_o),
      .unsupported_o(unsupported_o));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // file register and working register loaded in one cycle
   task automatic load(input logic [6:0] f, input logic [7:0] v, input logic [7:0] w);
      @(negedge sys_clk_i);
      file_load_i = 1'b1;
      file_addr_i = f;
      file_data_i = v;
      work_load_i = 1'b1;
      work_data_i = w;
      @(negedge sys_clk_i);
      file_load_i = 1'b0;
      work_load_i = 1'b0;
   endtask

   // issue one word, return at the negedge where the pulse is seen
   task automatic exec(input logic [13:0] word);
      int i;
      @(negedge sys_clk_i);
      insn_valid_i = 1'b1;
      insn_i       = word;
      @(negedge sys_clk_i);
      insn_valid_i = 1'b0;
      for (i = 0; i < 4 && done_o !== 1'b1 && unsupported_o !== 1'b1; i++) begin
         @(negedge sys_clk_i);
      end
      if (i == 4) begin
         err_total++;
         $display("unexpected pulse expected 1 seen none");
         wrap_up();
      end
      chk("latency", 8'(i + 1), 8'(DONE_LATENCY));
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_lsub(input logic [7:0] w, input logic [7:0] k, input logic x);
      logic [7:0] r;
      r = k - w;
      load(7'h00, 8'h00, w);
      exec({LSUB_OPC, x, k});
      chk("done", {7'h00, done_o}, 8'h01);
      chk("work", work_o, r);
      chk("zero", {7'h00, zero_flag_o}, {7'h00, r == 8'h00});
      chk("digit_carry", {7'h00, digit_carry_flag_o}, {7'h00, k[3:0] >= w[3:0]});
      chk("carry", {7'h00, carry_o}, {7'h00, k >= w});
      exp_c = (k >= w);
      exp_z = (r == 8'h00);
   endtask

   task automatic t_fsub(input logic [6:0] f, input logic [7:0] v, input logic [7:0] w,
                         input logic d);
      logic [7:0] r;
      r = v - w;
      load(f, v, w);
      exec({FSUB_OPC, d, f});
      chk("result", result_o, r);
      chk("zero", {7'h00, zero_flag_o}, {7'h00, r == 8'h00});
      chk("carry", {7'h00, carry_o}, {7'h00, v >= w});
      chk("work", work_o, d ? w : r);
      exp_c = (v >= w);
      exp_z = (r == 8'h00);
      if (d) begin
         exec({SWAP_OPC, 1'b0, f});
         chk("file", work_o, {r[3:0], r[7:4]});
      end
   endtask

   task automatic t_swap(input logic [6:0] f, input logic [7:0] v, input logic d);
      load(f, v, 8'h33);
      exec({SWAP_OPC, d, f});
      chk("result", result_o, {v[3:0], v[7:4]});
      chk("work", work_o, d ? 8'h33 : {v[3:0], v[7:4]});
      chk("carry", {7'h00, carry_o}, {7'h00, exp_c});
      chk("zero", {7'h00, zero_flag_o}, {7'h00, exp_z});
      if (d) begin
         exec({SWAP_OPC, 1'b0, f});
         chk("file", work_o, v);
      end
   endtask

   // subtract back to file, then swap that register in the very next cycle
   task automatic t_fwd(input logic [6:0] f, input logic [7:0] v, input logic [7:0] w);
      logic [7:0] r;
      r = v - w;
      load(f, v, w);
      @(negedge sys_clk_i);
      insn_valid_i = 1'b1;
      insn_i       = {FSUB_OPC, 1'b1, f};
      @(negedge sys_clk_i);
      insn_i       = {SWAP_OPC, 1'b0, f};
      @(negedge sys_clk_i);
      insn_valid_i = 1'b0;
      chk("result", result_o, r);
      chk("work", work_o, w);
      @(negedge sys_clk_i);
      chk("done", {7'h00, done_o}, 8'h01);
      chk("file", work_o, {r[3:0], r[7:4]});
   endtask

   task automatic t_unsupported;
      load(7'h00, 8'h00, 8'h44);
      exec(14'h3A55);
      chk("unsupported", {7'h00, unsupported_o}, 8'h01);
      chk("done", {7'h00, done_o}, 8'h01);
      @(negedge sys_clk_i);
      chk("work", work_o, 8'h44);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_i        = 1'b1;
      insn_valid_i = 1'b0;
      insn_i       = 14'h0000;
      work_load_i  = 1'b0;
      work_data_i  = 8'h00;
      file_load_i  = 1'b0;
      file_addr_i  = 7'h00;
      file_data_i  = 8'h00;
      repeat (10) @(negedge sys_clk_i);
      rst_i = 1'b0;
      chk("work", work_o, WORK_RST);
      chk("result", result_o, 8'h00);
      $display("test reset done");
      t_lsub(8'h01, 8'h02, 1'b0);
      t_lsub(8'h02, 8'h02, 1'b1);
      t_lsub(8'h03, 8'h02, 1'b0);
      t_lsub(8'h1F, 8'h20, 1'b1);
      $display("test literal subtract done");
      t_fsub(7'h05, 8'h03, 8'h02, 1'b1);
      t_fsub(7'h7F, 8'h02, 8'h02, 1'b1);
      t_fsub(7'h00, 8'h01, 8'h02, 1'b0);
      t_fsub(7'h40, 8'h80, 8'h7F, 1'b0);
      $display("test file subtract done");
      t_swap(7'h11, 8'hA5, 1'b0);
      t_lsub(8'h02, 8'h02, 1'b0);
      t_swap(7'h7F, 8'hC3, 1'b1);
      $display("test nibble swap done");
      t_fwd(7'h22, 8'h5A, 8'h13);
      $display("test back to back done");
      t_unsupported();
      $display("test unsupported done");
      wrap_up();
   end
endmodule
